// file: hdl/dsl_lock_fsm.sv
`timescale 1ns/10ps
module dsl_lock_fsm (
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic HARD_RESET,
  input wire logic TCG_ACTIVE,
  input wire logic MEDIA_REQ,
  output logic MEDIA_ALLOWED,
  output logic ERASE_PULSE,
  output logic IRQ,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR
);
  // =====================================================
  // pin synchronisers
  logic [1:0] pins_sync;
  dsl_sync #(.W(2)) u_sync (
    .CLK(CLK),
    .RSTN(RSTN),
    .D({HARD_RESET, TCG_ACTIVE}),
    .Q(pins_sync)
  );
  logic hard_rst_s;
  logic tcg_s;
  logic hard_rst_d_reg;
  logic hard_rst_rise;
  assign hard_rst_s = pins_sync[1];
  assign tcg_s = pins_sync[0];
  assign hard_rst_rise = hard_rst_s & ~hard_rst_d_reg;

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      hard_rst_d_reg <= 1'b0;
    end else begin
      hard_rst_d_reg <= hard_rst_s;
    end
  end

  // =====================================================
  // apb decode
  logic wr_en;
  logic rd_en;
  logic addr_ok;
  // zero wait states: every access completes in its first access cycle
  assign PREADY = 1'b1;
  assign wr_en = PSEL & PENABLE & PWRITE;
  assign rd_en = PSEL & PENABLE & ~PWRITE;
  always_comb begin
    case (PADDR)
      dsl_pkg::ADDR_CMD, dsl_pkg::ADDR_PASSWORD, dsl_pkg::ADDR_STATUS,
      dsl_pkg::ADDR_WORD92, dsl_pkg::ADDR_WORD128, dsl_pkg::ADDR_IRQ_STAT,
      dsl_pkg::ADDR_IRQ_MASK, dsl_pkg::ADDR_CONFIG, dsl_pkg::ADDR_RESULT:
        addr_ok = 1'b1;
      default:
        addr_ok = 1'b0;
    endcase
  end
  assign PSLVERR = PSEL & PENABLE & ~addr_ok;

  // =====================================================
  // command staging
  logic [dsl_pkg::PW_WIDTH-1:0] pw_in_reg;
  logic [dsl_pkg::PW_WIDTH-1:0] user_pw_reg;
  logic [dsl_pkg::PW_WIDTH-1:0] master_pw_reg;
  logic cmd_go;
  logic [7:0] cmd_op;
  logic cmd_master;
  logic cmd_maxlvl;
  logic [15:0] cmd_rev;
  assign cmd_go = wr_en && PADDR == dsl_pkg::ADDR_CMD;
  assign cmd_op = PWDATA[dsl_pkg::CMD_OP_LSB +: 8];
  assign cmd_master = PWDATA[dsl_pkg::CMD_MASTER_BIT];
  assign cmd_maxlvl = PWDATA[dsl_pkg::CMD_MAXLEVEL_BIT];
  assign cmd_rev = PWDATA[dsl_pkg::CMD_REV_LSB +: 16];

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      pw_in_reg <= '0;
    end else if (wr_en && PADDR == dsl_pkg::ADDR_PASSWORD) begin
      pw_in_reg <= PWDATA;
    end
  end

  // =====================================================
  // security state
  dsl_pkg::dsl_state_type state_reg;
  logic lock_en_reg;
  logic max_level_reg;
  logic erase_prep_reg;
  logic [15:0] master_rev_reg;
  logic [2:0] miss_cnt_reg;
  logic unlock_attempts_exhausted_flag;
  logic user_match;
  logic master_match;
  logic pw_match;
  logic is_sec_op;
  logic cmd_abort;
  logic cmd_ok;
  logic wrong_pw;
  logic pw_locked_out;
  logic frozen_block;
  logic locked_block;

  assign user_match = pw_in_reg == user_pw_reg;
  assign master_match = pw_in_reg == master_pw_reg;
  assign pw_match = cmd_master ? master_match : user_match;
  assign is_sec_op = cmd_op >= dsl_pkg::OP_SET_PASSWORD &&
                     cmd_op <= dsl_pkg::OP_DISABLE_PASSWORD;
  assign pw_locked_out = unlock_attempts_exhausted_flag &&
                         (cmd_op == dsl_pkg::OP_UNLOCK ||
                          cmd_op == dsl_pkg::OP_ERASE_UNIT);
  // frozen rejects every security command except freeze lock
  assign frozen_block = state_reg == dsl_pkg::ST_FROZEN &&
                        cmd_op != dsl_pkg::OP_FREEZE_LOCK;
  assign locked_block = state_reg == dsl_pkg::ST_LOCKED &&
                        (cmd_op == dsl_pkg::OP_SET_PASSWORD ||
                         cmd_op == dsl_pkg::OP_DISABLE_PASSWORD ||
                         cmd_op == dsl_pkg::OP_FREEZE_LOCK);
  // erase unit needs a prior erase prepare; only password checks count misses
  always_comb begin
    wrong_pw = 1'b0;
    case (cmd_op)
      dsl_pkg::OP_UNLOCK: begin
        // maximum level: master password cannot unlock directly
        wrong_pw = !pw_match || (cmd_master && max_level_reg);
      end
      dsl_pkg::OP_ERASE_UNIT: begin
        wrong_pw = !pw_match;
      end
      dsl_pkg::OP_DISABLE_PASSWORD: begin
        wrong_pw = !pw_match;
      end
      default: begin
        wrong_pw = 1'b0;
      end
    endcase
  end
  assign cmd_abort = cmd_go && is_sec_op &&
                     (tcg_s || pw_locked_out || frozen_block || locked_block ||
                      wrong_pw ||
                      (cmd_op == dsl_pkg::OP_ERASE_UNIT && !erase_prep_reg));
  assign cmd_ok = cmd_go && is_sec_op && !cmd_abort;
  logic miss_cnt_en;
  // a command refused for tcg, lockout, frozen or locked does not count a miss; nor does one refused only for a missing erase prepare
  assign miss_cnt_en = cmd_go && is_sec_op && wrong_pw && !tcg_s && !pw_locked_out &&
                       !frozen_block && !locked_block;

  dsl_pkg::dsl_state_type state_next;
  // a frozen drive stays frozen through hard reset; only power-on leaves it
  always_comb begin
    state_next = state_reg;
    if (hard_rst_rise && state_reg != dsl_pkg::ST_FROZEN) begin
      state_next = lock_en_reg ? dsl_pkg::ST_LOCKED : dsl_pkg::ST_UNLOCKED;
    end else if (!lock_en_reg && state_reg == dsl_pkg::ST_LOCKED) begin
      state_next = dsl_pkg::ST_UNLOCKED;
    end else if (cmd_ok) begin
      case (cmd_op)
        dsl_pkg::OP_UNLOCK, dsl_pkg::OP_ERASE_UNIT: begin
          if (state_reg == dsl_pkg::ST_LOCKED) begin
            state_next = dsl_pkg::ST_UNLOCKED;
          end
        end
        dsl_pkg::OP_FREEZE_LOCK: begin
          state_next = dsl_pkg::ST_FROZEN;
        end
        default: begin
          state_next = state_reg;
        end
      endcase
    end
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      state_reg <= dsl_pkg::ST_UNLOCKED;
    end else begin
      state_reg <= state_next;
    end
  end

  // lock_en survives hard reset but not power-on; it enters at power-on as off
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      lock_en_reg <= 1'b0;
      max_level_reg <= 1'b0;
      user_pw_reg <= '0;
      master_pw_reg <= '0;
      master_rev_reg <= dsl_pkg::MASTER_REV_DEFAULT;
    end else if (cmd_ok) begin
      case (cmd_op)
        dsl_pkg::OP_SET_PASSWORD: begin
          if (cmd_master) begin
            master_pw_reg <= pw_in_reg;
            if (cmd_rev >= dsl_pkg::MASTER_REV_MIN && cmd_rev <= dsl_pkg::MASTER_REV_MAX) begin
              master_rev_reg <= cmd_rev;
            end
          end else begin
            user_pw_reg <= pw_in_reg;
            lock_en_reg <= 1'b1;
            max_level_reg <= cmd_maxlvl;
          end
        end
        dsl_pkg::OP_ERASE_UNIT, dsl_pkg::OP_DISABLE_PASSWORD: begin
          lock_en_reg <= 1'b0;
          user_pw_reg <= '0;
        end
        default: begin
          lock_en_reg <= lock_en_reg;
        end
      endcase
    end
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      erase_prep_reg <= 1'b0;
    end else if (hard_rst_rise) begin
      erase_prep_reg <= 1'b0;
    end else if (cmd_go && is_sec_op) begin
      erase_prep_reg <= cmd_ok && cmd_op == dsl_pkg::OP_ERASE_PREPARE;
    end
  end

  // counter saturates; only resets clear it
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      miss_cnt_reg <= '0;
      unlock_attempts_exhausted_flag <= 1'b0;
    end else if (hard_rst_rise) begin
      miss_cnt_reg <= '0;
      unlock_attempts_exhausted_flag <= 1'b0;
    end else if (miss_cnt_en) begin
      // stop at all ones so later misses cannot wrap back to a low count
      if (miss_cnt_reg != '1) begin
        miss_cnt_reg <= miss_cnt_reg + 3'h1;
      end
      if (32'(miss_cnt_reg) + 1 >= dsl_pkg::ATTEMPT_LIMIT) begin
        unlock_attempts_exhausted_flag <= 1'b1;
      end
    end
  end

  // =====================================================
  // outputs
  // media gate is registered so a state change and a request never race
  logic last_abort_reg;
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      ERASE_PULSE <= 1'b0;
      MEDIA_ALLOWED <= 1'b0;
      last_abort_reg <= 1'b0;
    end else begin
      ERASE_PULSE <= cmd_ok && cmd_op == dsl_pkg::OP_ERASE_UNIT;
      MEDIA_ALLOWED <= MEDIA_REQ && state_reg != dsl_pkg::ST_LOCKED;
      if (cmd_go && is_sec_op) begin
        last_abort_reg <= cmd_abort;
      end
    end
  end

  // =====================================================
  // interrupts
  logic [dsl_pkg::IRQ_W-1:0] irq_stat_reg;
  logic [dsl_pkg::IRQ_W-1:0] irq_mask_reg;
  logic [dsl_pkg::IRQ_W-1:0] irq_evt;
  always_comb begin
    irq_evt = '0;
    irq_evt[dsl_pkg::IRQ_DONE] = cmd_ok;
    irq_evt[dsl_pkg::IRQ_ABORT] = cmd_abort;
    // same qualifier as the counter, so the event and the flag never disagree
    irq_evt[dsl_pkg::IRQ_UNLOCK_ATTEMPTS_EXHAUSTED_FLAG] = miss_cnt_en &&
                                   32'(miss_cnt_reg) + 1 == dsl_pkg::ATTEMPT_LIMIT;
    irq_evt[dsl_pkg::IRQ_ERASE] = cmd_ok && cmd_op == dsl_pkg::OP_ERASE_UNIT;
  end
  // set wins over a write-one clear in the same cycle
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      irq_stat_reg <= '0;
    end else begin
      irq_stat_reg <= (irq_stat_reg &
                       ~((wr_en && PADDR == dsl_pkg::ADDR_IRQ_STAT) ?
                         PWDATA[dsl_pkg::IRQ_W-1:0] : '0)) | irq_evt;
    end
  end
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      irq_mask_reg <= '0;
    end else if (wr_en && PADDR == dsl_pkg::ADDR_IRQ_MASK) begin
      irq_mask_reg <= PWDATA[dsl_pkg::IRQ_W-1:0];
    end
  end
  assign IRQ = |(irq_stat_reg & irq_mask_reg);

  // =====================================================
  // read mux
  logic [31:0] status_word;
  logic [31:0] word128;
  always_comb begin
    status_word = '0;
    status_word[dsl_pkg::ST_STATE_LSB +: 2] = state_reg;
    status_word[dsl_pkg::ST_LOCKEN_BIT] = lock_en_reg;
    status_word[dsl_pkg::ST_MAXLVL_BIT] = max_level_reg;
    status_word[dsl_pkg::ST_UNLOCK_ATTEMPTS_EXHAUSTED_FLAG_BIT] = unlock_attempts_exhausted_flag;
    status_word[dsl_pkg::ST_ERASE_PREP_BIT] = erase_prep_reg;
    status_word[dsl_pkg::ST_MEDIA_OK_BIT] = state_reg != dsl_pkg::ST_LOCKED;
    status_word[dsl_pkg::ST_CNT_LSB +: 3] = miss_cnt_reg;
    word128 = '0;
    word128[dsl_pkg::UNLOCK_ATTEMPTS_EXHAUSTED_FLAG_BIT] = unlock_attempts_exhausted_flag;
    word128[dsl_pkg::W128_SUPPORTED_BIT] = 1'b1;
    word128[dsl_pkg::W128_ENABLED_BIT] = lock_en_reg;
    word128[dsl_pkg::W128_LOCKED_BIT] = state_reg == dsl_pkg::ST_LOCKED;
    word128[dsl_pkg::W128_FROZEN_BIT] = state_reg == dsl_pkg::ST_FROZEN;
    word128[dsl_pkg::W128_LEVEL_BIT] = max_level_reg;
  end
  // read data is captured in setup so it stands through the access edge
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      PRDATA <= '0;
    end else if (PSEL && !PENABLE && !PWRITE) begin
      case (PADDR)
        dsl_pkg::ADDR_STATUS: PRDATA <= status_word;
        dsl_pkg::ADDR_WORD92: PRDATA <= {16'h0000, master_rev_reg};
        dsl_pkg::ADDR_WORD128: PRDATA <= word128;
        dsl_pkg::ADDR_IRQ_STAT: PRDATA <= {{(32 - dsl_pkg::IRQ_W){1'b0}}, irq_stat_reg};
        dsl_pkg::ADDR_IRQ_MASK: PRDATA <= {{(32 - dsl_pkg::IRQ_W){1'b0}}, irq_mask_reg};
        dsl_pkg::ADDR_RESULT: PRDATA <= {31'h00000000, last_abort_reg};
        default: PRDATA <= 32'h00000000;
      endcase
    end
  end
  logic unused_rd;
  assign unused_rd = rd_en;
endmodule : dsl_lock_fsm

// file: hdl/dsl_pkg.sv
package dsl_pkg;
  localparam logic [7:0] OP_SET_PASSWORD = 8'hF1;
  localparam logic [7:0] OP_UNLOCK = 8'hF2;
  localparam logic [7:0] OP_ERASE_PREPARE = 8'hF3;
  localparam logic [7:0] OP_ERASE_UNIT = 8'hF4;
  localparam logic [7:0] OP_FREEZE_LOCK = 8'hF5;
  localparam logic [7:0] OP_DISABLE_PASSWORD = 8'hF6;
  localparam logic [15:0] MASTER_REV_DEFAULT = 16'hFFFE;
  localparam logic [15:0] MASTER_REV_MIN = 16'h0001;
  localparam logic [15:0] MASTER_REV_MAX = 16'hFFFE;
  localparam int ATTEMPT_LIMIT = 5;
  localparam int UNLOCK_ATTEMPTS_EXHAUSTED_FLAG_BIT = 4;
  // identification word 128 field positions
  localparam int W128_SUPPORTED_BIT = 0;
  localparam int W128_ENABLED_BIT = 1;
  localparam int W128_LOCKED_BIT = 2;
  localparam int W128_FROZEN_BIT = 3;
  localparam int W128_LEVEL_BIT = 8;
  localparam int PW_WIDTH = 32;
  // apb register byte addresses
  localparam logic [11:0] ADDR_CMD = 12'h000;
  localparam logic [11:0] ADDR_PASSWORD = 12'h004;
  localparam logic [11:0] ADDR_STATUS = 12'h008;
  localparam logic [11:0] ADDR_WORD92 = 12'h00C;
  localparam logic [11:0] ADDR_WORD128 = 12'h010;
  localparam logic [11:0] ADDR_IRQ_STAT = 12'h014;
  localparam logic [11:0] ADDR_IRQ_MASK = 12'h018;
  localparam logic [11:0] ADDR_CONFIG = 12'h01C;
  localparam logic [11:0] ADDR_RESULT = 12'h020;
  // command register fields
  localparam int CMD_OP_LSB = 0;
  localparam int CMD_MASTER_BIT = 8;
  localparam int CMD_MAXLEVEL_BIT = 9;
  localparam int CMD_REV_LSB = 16;
  // status register fields
  localparam int ST_STATE_LSB = 0;
  localparam int ST_LOCKEN_BIT = 2;
  localparam int ST_MAXLVL_BIT = 3;
  localparam int ST_UNLOCK_ATTEMPTS_EXHAUSTED_FLAG_BIT = 4;
  localparam int ST_ERASE_PREP_BIT = 5;
  localparam int ST_MEDIA_OK_BIT = 6;
  localparam int ST_CNT_LSB = 8;
  // interrupt bits
  localparam int IRQ_DONE = 0;
  localparam int IRQ_ABORT = 1;
  localparam int IRQ_UNLOCK_ATTEMPTS_EXHAUSTED_FLAG = 2;
  localparam int IRQ_ERASE = 3;
  localparam int IRQ_W = 4;
  typedef enum logic [1:0] {
    ST_UNLOCKED,
    ST_LOCKED,
    ST_FROZEN
  } dsl_state_type;
endpackage : dsl_pkg

// file: hdl/dsl_sync.sv
`timescale 1ns/10ps
module dsl_sync #(
  parameter int W = 1
) (
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic [W-1:0] D,
  output logic [W-1:0] Q
);
  logic [W-1:0] meta_reg;

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      meta_reg <= '0;
      Q <= '0;
    end else begin
      meta_reg <= D;
      Q <= meta_reg;
    end
  end
endmodule : dsl_sync

// file: bench/dsl_lock_fsm_props.sv
`timescale 1ns/10ps
// ==========
// port checker
module dsl_lock_fsm_props (
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic HARD_RESET,
  input wire logic TCG_ACTIVE,
  input wire logic MEDIA_REQ,
  input wire logic MEDIA_ALLOWED,
  input wire logic ERASE_PULSE,
  input wire logic IRQ,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR
);
  logic wr4;
  assign wr4 = PSEL && PENABLE && PWRITE && PADDR == dsl_pkg::ADDR_CMD
    && PWDATA[7:0] == dsl_pkg::OP_ERASE_UNIT;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RSTN);
  reset_quiet_a: assert property ($rose(RSTN) |-> !MEDIA_ALLOWED && !ERASE_PULSE && !IRQ)
    else $error("outputs busy after reset");
  media_gate_a: assert property (MEDIA_ALLOWED |-> $past(MEDIA_REQ))
    else $error("media allowed without request");
  pready_high_a: assert property (PREADY)
    else $error("pready low");
  slverr_phase_a: assert property (PSLVERR |-> PSEL && PENABLE)
    else $error("slverr outside access");
  unmapped_read_a: assert property (
    PSEL && !PENABLE && !PWRITE && PADDR > dsl_pkg::ADDR_RESULT |=> PRDATA == 32'h0)
    else $error("unmapped read not zero");
  erase_single_a: assert property (ERASE_PULSE |=> !ERASE_PULSE)
    else $error("erase pulse too long");
  erase_cause_a: assert property ($rose(ERASE_PULSE) |-> $past(wr4) || $past(wr4, 2))
    else $error("erase without erase unit command");
  tcg_block_a: assert property (TCG_ACTIVE [*6] |=> !ERASE_PULSE)
    else $error("erase while trusted storage active");
  irq_cause_a: assert property ($rose(IRQ) |-> $past(PSEL && PENABLE && PWRITE))
    else $error("irq rose without write");
  erase_c: cover property ($rose(ERASE_PULSE));
  irq_c: cover property ($rose(IRQ));
  slverr_c: cover property (PSLVERR);
endmodule : dsl_lock_fsm_props

bind dsl_lock_fsm dsl_lock_fsm_props i_props (.CLK, .RSTN, .HARD_RESET, .TCG_ACTIVE, .MEDIA_REQ,
  .MEDIA_ALLOWED, .ERASE_PULSE, .IRQ, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA,
  .PREADY, .PSLVERR);

// file: bench/dsl_host_model.sv
`timescale 1ns/10ps
// ==========
// host issuing security commands over apb
module dsl_host_model (
  input wire logic CLK,
  input wire logic PREADY,
  input wire logic [31:0] PRDATA,
  input wire logic PSLVERR,
  output logic PSEL,
  output logic PENABLE,
  output logic PWRITE,
  output logic [11:0] PADDR,
  output logic [31:0] PWDATA
);
  initial begin
    PSEL = 1'b0;
    PENABLE = 1'b0;
    PWRITE = 1'b0;
    PADDR = 12'h0;
    PWDATA = 32'h0;
  end
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    @(posedge CLK);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK);
    PENABLE <= 1'b1;
    do @(posedge CLK); while (PREADY !== 1'b1);
    q = PRDATA;
    e = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    // released lines must not keep showing the old request
    PADDR <= ~a;
    PWDATA <= ~d;
  endtask : xfer
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    xfer(1'b1, a, d, q, e);
  endtask : wr
  // password word goes first so the command sees it
  task automatic cmd(input logic [7:0] op, input logic m, input logic [31:0] pw,
                     input logic [31:0] hi);
    wr(dsl_pkg::ADDR_PASSWORD, pw);
    wr(dsl_pkg::ADDR_CMD, hi | {23'h0, m, op});
  endtask : cmd
endmodule : dsl_host_model

// file: bench/testbench.sv
`timescale 1ns/10ps
module testbench;
  localparam logic [1:0] SU = 2'h0;
  localparam logic [1:0] SL = 2'h1;
  localparam logic [1:0] SF = 2'h2;
  logic clk, rstn, hard_reset, tcg_active, media_req, er, r;
  logic psel, penable, pwrite, pready, pslverr, media_allowed, erase_pulse, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q, pw, mpw, rev;
  int mismatches, n_compared, n_erase;
  dsl_lock_fsm i_dut (.CLK(clk), .RSTN(rstn), .HARD_RESET(hard_reset), .TCG_ACTIVE(tcg_active),
    .MEDIA_REQ(media_req), .MEDIA_ALLOWED(media_allowed), .ERASE_PULSE(erase_pulse), .IRQ(irq),
    .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr));
  dsl_host_model i_host (.CLK(clk), .PREADY(pready), .PRDATA(prdata), .PSLVERR(pslverr),
    .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata));
  initial clk = 1'b0;
  always #50 clk = ~clk;
  always @(posedge clk) if (erase_pulse === 1'b1) n_erase <= n_erase + 1;
  // ==========
  // checking helpers
  task automatic give_verdict;
    if (mismatches == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : give_verdict
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic rdchk(input string n, input logic [11:0] a, input logic [31:0] m,
                       input logic [31:0] e);
    i_host.xfer(1'b0, a, 32'h0, q, er);
    chk(n, e, q & m);
  endtask : rdchk
  function automatic logic [31:0] exp_st(input logic [1:0] s, input logic l, input logic [2:0] c);
    return {21'h0, c, 3'h0, c >= 3'h5, 1'b0, l, s};
  endfunction : exp_st
  task automatic st(input logic [1:0] s, input logic l, input logic [2:0] c);
    rdchk("status", dsl_pkg::ADDR_STATUS, 32'h0000_0717, exp_st(s, l, c));
  endtask : st
  task automatic res(input logic a);
    rdchk("aborted", dsl_pkg::ADDR_RESULT, 32'h1, {31'h0, a});
  endtask : res
  task automatic hreset;
    @(posedge clk);
    hard_reset <= 1'b1;
    repeat (4) @(posedge clk);
    hard_reset <= 1'b0;
    repeat (4) @(posedge clk);
  endtask : hreset
  task automatic irqchk(input logic e);
    @(negedge clk);
    chk("irq", {31'h0, e}, {31'h0, irq});
  endtask : irqchk
  task automatic media(input logic open);
    repeat (4) begin
      r = 1'($urandom);
      @(posedge clk);
      media_req <= r;
      @(posedge clk);
      @(negedge clk);
      chk("media", {31'h0, r & open}, {31'h0, media_allowed});
    end
  endtask : media
  // ==========
  // main sequence
  initial begin
    rstn = 1'b0;
    hard_reset = 1'b0;
    tcg_active = 1'b0;
    media_req = 1'b0;
    void'($urandom(69436));
    pw = $urandom;
    mpw = ~pw;
    rev = (32'h1 + $urandom % 32'hFFFE) << 16;
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    st(SU, 1'b0, 3'h0);
    rdchk("word92", dsl_pkg::ADDR_WORD92, 32'hFFFF, 32'hFFFE);
    media(1'b1);
    i_host.xfer(1'b0, 12'h024, 32'h0, q, er);
    chk("slverr", 32'h1, {31'h0, er});
    chk("unmapped", 32'h0, q);
    i_host.cmd(dsl_pkg::OP_SET_PASSWORD, 1'b1, mpw, rev);
    rdchk("word92", dsl_pkg::ADDR_WORD92, 32'hFFFF, rev >> 16);
    hreset();
    st(SU, 1'b0, 3'h0);
    i_host.wr(dsl_pkg::ADDR_IRQ_MASK, 32'h1 << dsl_pkg::IRQ_UNLOCK_ATTEMPTS_EXHAUSTED_FLAG);
    i_host.cmd(dsl_pkg::OP_SET_PASSWORD, 1'b0, pw, 32'h0);
    st(SU, 1'b1, 3'h0);
    hreset();
    st(SL, 1'b1, 3'h0);
    media(1'b0);
    for (int i = 1; i <= dsl_pkg::ATTEMPT_LIMIT; i++) begin
      i_host.cmd(dsl_pkg::OP_UNLOCK, 1'($urandom), pw ^ (($urandom | 32'h1) & 32'h7FFF_FFFF), 0);
      st(SL, 1'b1, 3'(i));
    end
    irqchk(1'b1);
    rdchk("word128", dsl_pkg::ADDR_WORD128, 32'h10, 32'h10);
    i_host.cmd(dsl_pkg::OP_UNLOCK, 1'b0, pw, 32'h0);
    res(1'b1);
    i_host.wr(dsl_pkg::ADDR_IRQ_MASK, 32'h0);
    irqchk(1'b0);
    i_host.wr(dsl_pkg::ADDR_IRQ_MASK, 32'h4);
    irqchk(1'b1);
    i_host.wr(dsl_pkg::ADDR_IRQ_STAT, 32'h4);
    irqchk(1'b0);
    hreset();
    st(SL, 1'b1, 3'h0);
    i_host.cmd(dsl_pkg::OP_UNLOCK, 1'b1, mpw, 32'h0);
    st(SU, 1'b1, 3'h0);
    i_host.cmd(dsl_pkg::OP_FREEZE_LOCK, 1'b0, pw, 32'h0);
    st(SF, 1'b1, 3'h0);
    i_host.cmd(dsl_pkg::OP_DISABLE_PASSWORD, 1'b0, pw, 32'h0);
    res(1'b1);
    media(1'b1);
    hreset();
    st(SF, 1'b1, 3'h0);
    // power-on reset in mid-run: the only way out of the frozen state
    @(posedge clk);
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    st(SU, 1'b0, 3'h0);
    rdchk("word92", dsl_pkg::ADDR_WORD92, 32'hFFFF, 32'hFFFE);
    i_host.cmd(dsl_pkg::OP_SET_PASSWORD, 1'b1, mpw, rev);
    i_host.cmd(dsl_pkg::OP_SET_PASSWORD, 1'b0, pw, 32'h200);
    hreset();
    i_host.cmd(dsl_pkg::OP_UNLOCK, 1'b1, mpw, 32'h0);
    st(SL, 1'b1, 3'h1);
    i_host.cmd(dsl_pkg::OP_ERASE_PREPARE, 1'b1, mpw, 32'h0);
    i_host.cmd(dsl_pkg::OP_ERASE_UNIT, 1'b1, mpw, 32'h0);
    st(SU, 1'b0, 3'h1);
    chk("erase", 32'h1, 32'(n_erase));
    tcg_active <= 1'b1;
    repeat (4) @(posedge clk);
    i_host.cmd(dsl_pkg::OP_FREEZE_LOCK, 1'b0, pw, 32'h0);
    res(1'b1);
    tcg_active <= 1'b0;
    repeat (4) @(posedge clk);
    i_host.cmd(dsl_pkg::OP_FREEZE_LOCK, 1'b0, pw, 32'h0);
    st(SF, 1'b0, 3'h1);
    give_verdict();
  end
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    give_verdict();
  end
endmodule : testbench
